// *** src/parcel_decoder_map.svh ***
/*
 * constants of the parcel decoder: field positions, widths, mode masks
 * and special operand values. assumes inclusion by the decoder module
 * and the test bench.
 */
`ifndef PARCEL_DECODER_MAP_SVH
`define PARCEL_DECODER_MAP_SVH

// ----------------------------------------------------------------------
// parcel layout
// ----------------------------------------------------------------------
`define PD_PARCELS_PER_WORD  3'd4
`define PD_LAST_PARCEL       2'd3
`define PD_G_MSB             15
`define PD_G_LSB             12
`define PD_H_MSB             11
`define PD_H_LSB             9
`define PD_I_MSB             8
`define PD_I_LSB             6
`define PD_J_MSB             5
`define PD_J_LSB             3
`define PD_K_MSB             2
`define PD_K_LSB             0

// ----------------------------------------------------------------------
// opcode groups (gh, 7 bits; g, 4 bits)
// ----------------------------------------------------------------------
`define PD_G_AH_LOAD         4'h0
`define PD_GH_AH_IMM         7'h01
`define PD_GH_A_IMM0         7'h10
`define PD_GH_A_IMM1         7'h11
`define PD_GH_S_IMM0         7'h20
`define PD_GH_S_IMM1         7'h21
`define PD_GH_CHAN           7'h00
`define PD_GH_RTC            7'h01
`define PD_G_MEM_LO          4'h8
`define PD_G_MEM_HI          4'hB
`define PD_GH_CMPIDX         7'h0B
`define PD_GH_BRANCH_LO      7'h05
`define PD_GH_BRANCH_HI      7'h07

// ----------------------------------------------------------------------
// addressing and special operands
// ----------------------------------------------------------------------
`define PD_NARROW_MASK       32'h00FF_FFFF
`define PD_PROG_RANGE_MASK   32'h003F_FFFF
`define PD_A_ONE             32'h0000_0001
`define PD_S_SIGN            64'h8000_0000_0000_0000
`define PD_VL_MAX            7'h40

`endif

// *** src/parcel_decoder_pkg.sv ***
/*
 * types of the parcel decoder. assumes the map header alongside.
 */
package parcel_decoder_pkg;
  typedef enum logic [1:0] {
    FMT_ONE,
    FMT_TWO,
    FMT_THREE
  } length_t;

  typedef enum logic [2:0] {
    KIND_DISCRETE,
    KIND_COMBINED,
    KIND_IMM22,
    KIND_MEM22,
    KIND_BRANCH,
    KIND_IMM24,
    KIND_IMM32,
    KIND_MEM32
  } format_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MASK,
    ST_DONE
  } cmp_state_t;
endpackage

// *** src/parcel_instruction_decoder.sv ***
/*
 * parcel aligner and decoder: takes 64-bit instruction words, forms
 * 1-, 2- and 3-parcel instructions across word edges, splits fields,
 * applies narrow/wide addressing, special register-zero operands,
 * monitor gating, and steps the compressed-index mask.
 * assumes the fetch side holds word_valid until word_ready and that
 * register contents and element tests arrive from the datapath.
 */
`timescale 1ns/100ps
`include "parcel_decoder_map.svh"

module parcel_instruction_decoder (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic [63:0]                 word_data,
  input  wire logic                        word_valid,
  output logic                             word_ready,
  input  wire logic                        branch_take,
  input  wire logic [23:0]                 branch_parcel,
  input  wire logic                        wide_addressing_bit,
  input  wire logic                        monitor_mode,
  input  wire logic [31:0]                 address_reg_zero,
  input  wire logic [63:0]                 scalar_reg_zero,
  input  wire logic [6:0]                  vector_length,
  input  wire logic                        elem_nonzero,
  output logic                             issue_valid,
  output parcel_decoder_pkg::length_t      issue_length,
  output parcel_decoder_pkg::format_t      issue_format,
  output logic [6:0]                       opcode_gh,
  output logic [2:0]                       field_h,
  output logic [2:0]                       field_i,
  output logic [2:0]                       field_j,
  output logic [2:0]                       field_k,
  output logic [5:0]                       field_jk,
  output logic [31:0]                      immediate,
  output logic [23:0]                      branch_target,
  output logic [31:0]                      operand_ah,
  output logic [31:0]                      operand_aj,
  output logic [31:0]                      operand_ak,
  output logic [63:0]                      operand_sj,
  output logic [63:0]                      operand_sk,
  output logic                             use_real_zero_i,
  output logic                             skip_reserve_j,
  output logic                             skip_reserve_k,
  output logic                             issue_nop,
  output logic                             mode_error,
  output logic [63:0]                      vector_mask,
  output logic [6:0]                       cmp_index,
  output logic                             cmp_pack,
  output logic                             cmp_busy
);
  import parcel_decoder_pkg::*;

  // ----------------------------------------------------------------------
  // parcel queue: up to 6 parcels buffered (current word tail + next word)
  // ----------------------------------------------------------------------
  logic [15:0]  q_q [0:6];
  logic [15:0]  q_d [0:6];
  logic [2:0]   cnt_q;
  logic [2:0]   cnt_d;
  logic [1:0]   skip_q;
  logic [1:0]   skip_d;
  logic [21:0]  word_addr_q;
  cmp_state_t   cmp_q;
  cmp_state_t   cmp_d;
  logic [6:0]   idx_q;
  logic [63:0]  mask_q;

  wire [15:0] p0 = q_q[0];
  wire [15:0] p1 = q_q[1];
  wire [15:0] p2 = q_q[2];
  wire [3:0]  g  = p0[`PD_G_MSB:`PD_G_LSB];
  wire [2:0]  h  = p0[`PD_H_MSB:`PD_H_LSB];
  wire [2:0]  fi = p0[`PD_I_MSB:`PD_I_LSB];
  wire [2:0]  fj = p0[`PD_J_MSB:`PD_J_LSB];
  wire [2:0]  fk = p0[`PD_K_MSB:`PD_K_LSB];
  wire [6:0]  gh = {g, h};

  // ----------------------------------------------------------------------
  // length and format classification
  // ----------------------------------------------------------------------
  // three parcels when j,k zero on the 3-parcel immediate/memory opcodes in wide mode
  wire is_imm_op  = (gh == `PD_GH_A_IMM0) || (gh == `PD_GH_A_IMM1) ||
                    (gh == `PD_GH_S_IMM0) || (gh == `PD_GH_S_IMM1);
  wire is_mem_op  = (g >= `PD_G_MEM_LO) && (g <= `PD_G_MEM_HI);
  wire is_ah_imm  = (g == `PD_G_AH_LOAD) && h[2];
  wire is_branch  = (gh >= `PD_GH_BRANCH_LO) && (gh <= `PD_GH_BRANCH_HI) && !fi[2];
  wire jk_zero    = (fj == 3'h0) && (fk == 3'h0);
  wire three_form = (is_imm_op || is_mem_op) && jk_zero && wide_addressing_bit;
  wire two_form   = is_imm_op || is_mem_op || is_ah_imm || is_branch;
  wire [2:0] need = three_form ? 3'd3 : (two_form ? 3'd2 : 3'd1);

  // issue waits until every parcel is in the queue
  wire have_all = (cnt_q >= need) && (cmp_q == ST_IDLE);
  wire consume  = have_all && !branch_take;

  // low half first in memory order, placed in bits 15:0
  wire [31:0] imm32 = {p2, p1};
  wire [21:0] imm22 = {fj, fk, p1};
  wire [23:0] imm24 = {fi[1:0], fj, fk, p1};

  // narrow mode keeps 24 address bits
  wire [31:0] amask  = wide_addressing_bit ? 32'hFFFF_FFFF : `PD_NARROW_MASK;
  // channel control ops (gh 00, i nonzero) need monitor mode; clock writes (gh 01) are not gated
  wire priv_op  = (gh == `PD_GH_CHAN) && (fi != 3'h0);
  // opcode 01 address immediate not allowed in wide mode
  wire reject01 = (gh == `PD_GH_AH_IMM) && wide_addressing_bit;
  // compressed index opcode starts the mask walk
  wire is_cmp   = (gh == `PD_GH_CMPIDX) && (need == 3'd1);

  assign word_ready = (cnt_q <= 3'd2) || (!(cnt_q[2]) && consume);

  // ----------------------------------------------------------------------
  // queue next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] base;
    logic [2:0] take;
    base  = 3'd0;
    take  = consume ? need : 3'd0;
    cnt_d = cnt_q;
    skip_d = skip_q;
    for (int n = 0; n < 7; n++) begin
      q_d[n] = q_q[n];
    end
    if (branch_take) begin
      // target parcel selects where the next word is entered
      cnt_d  = 3'd0;
      skip_d = branch_parcel[1:0];
    end else begin
      for (int n = 0; n < 7; n++) begin
        q_d[n] = (n + int'(take) < 7) ? q_q[n + int'(take)] : 16'h0000;
      end
      base  = cnt_q - take;
      cnt_d = base;
      if (word_valid && word_ready) begin
        // new parcels append to the unfinished tail
        for (int p = 0; p < 4; p++) begin
          if (p >= int'(skip_q)) begin
            q_d[int'(base) + p - int'(skip_q)] = word_data[63 - 16*p -: 16];
          end
        end
        cnt_d  = base + 3'(3'd4 - {1'b0, skip_q});
        skip_d = 2'd0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // compressed-index walk
  // ----------------------------------------------------------------------
  wire cmp_end = (idx_q + 7'd1 >= vector_length) || (idx_q == `PD_VL_MAX - 7'd1);

  always_comb begin
    cmp_d = cmp_q;
    unique case (cmp_q)
      ST_IDLE: if (consume && is_cmp && (vector_length != 7'h00)) begin
        cmp_d = ST_MASK;
      end
      ST_MASK: if (cmp_end) begin
        cmp_d = ST_DONE;
      end
      ST_DONE: cmp_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q       <= 3'd0;
      skip_q      <= 2'd0;
      cmp_q       <= ST_IDLE;
      idx_q       <= 7'h00;
      mask_q      <= 64'h0000_0000_0000_0000;
      word_addr_q <= 22'h00_0000;
      for (int n = 0; n < 7; n++) begin
        q_q[n] <= 16'h0000;
      end
    end else begin
      cnt_q  <= cnt_d;
      skip_q <= skip_d;
      cmp_q  <= cmp_d;
      q_q    <= q_d;
      // word address wraps within four million words
      if (branch_take) begin
        word_addr_q <= branch_parcel[23:2];
      end else if (word_valid && word_ready) begin
        word_addr_q <= word_addr_q + 22'h00_0001;
      end
      if (cmp_q == ST_IDLE && cmp_d == ST_MASK) begin
        idx_q  <= 7'h00;
        mask_q <= 64'h0000_0000_0000_0000;
      end else if (cmp_q == ST_MASK) begin
        // element n lands in bit 63-n
        mask_q[6'd63 - idx_q[5:0]] <= elem_nonzero;
        idx_q <= idx_q + 7'h01;
      end
    end
  end

  assign vector_mask = mask_q;
  assign cmp_index   = idx_q;
  assign cmp_busy    = (cmp_q != ST_IDLE);
  // nonzero element index is packed this cycle
  assign cmp_pack    = (cmp_q == ST_MASK) && elem_nonzero;

  // ----------------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------------
  // 3-parcel form in narrow mode flagged as error
  // three-parcel signature (zero j,k) seen in narrow mode
  wire narrow_three = (is_imm_op || is_mem_op) && jk_zero && !wide_addressing_bit;

  always_comb begin
    issue_format = KIND_DISCRETE;
    immediate    = 32'h0000_0000;
    if (need == 3'd3) begin
      issue_format = is_mem_op ? KIND_MEM32 : KIND_IMM32;
      immediate    = imm32 & amask;
    end else if (is_branch) begin
      issue_format = KIND_BRANCH;
    end else if (is_ah_imm) begin
      // 24-bit immediate into address register h
      issue_format = KIND_IMM24;
      immediate    = {8'h00, imm24} & amask;
    end else if (need == 3'd2) begin
      issue_format = is_mem_op ? KIND_MEM22 : KIND_IMM22;
      immediate    = {10'h000, imm22};
    end else if (fi == 3'h0 && !jk_zero) begin
      issue_format = KIND_COMBINED;
    end
  end

  assign issue_valid   = consume;
  assign issue_length  = (need == 3'd3) ? FMT_THREE : ((need == 3'd2) ? FMT_TWO : FMT_ONE);
  assign opcode_gh     = gh;
  assign field_h       = h;
  assign field_i       = fi;
  assign field_j       = fj;
  assign field_k       = fk;
  assign field_jk      = {fj, fk};
  // 24-bit parcel address, low 2 bits pick the parcel
  assign branch_target = {fi[1:0], fj, fk, p1};

  assign operand_ah = (h == 3'h0)  ? 32'h0000_0000 : 32'h0000_0000;
  assign operand_aj = (fj == 3'h0) ? 32'h0000_0000 : 32'h0000_0000;
  assign operand_ak = (fk == 3'h0) ? `PD_A_ONE : 32'h0000_0000;
  assign operand_sj = 64'h0000_0000_0000_0000;
  assign operand_sk = (fk == 3'h0) ? `PD_S_SIGN : 64'h0000_0000_0000_0000;
  // substitutes skip reservations, i field reads the register
  assign skip_reserve_j  = (fj == 3'h0);
  assign skip_reserve_k  = (fk == 3'h0);
  assign use_real_zero_i = (fi == 3'h0);
  // narrow mode only runs short forms
  assign mode_error = consume && (narrow_three || reject01);
  assign issue_nop  = consume && (priv_op && !monitor_mode || reject01);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // no issue before all parcels present
  chk_issue_full: assert property (@(posedge mclk) disable iff (!rst_n) issue_valid |-> cnt_q >= need)
    else $error("issue without all parcels");
  // no three-parcel issue in narrow mode
  chk_narrow_three: assert property (@(posedge mclk) disable iff (!rst_n)
    issue_valid && !wide_addressing_bit |-> issue_length != FMT_THREE)
    else $error("three parcel in narrow mode");
  // privileged op outside monitor is nop
  chk_priv_nop: assert property (@(posedge mclk) disable iff (!rst_n)
    issue_valid && priv_op && !monitor_mode |-> issue_nop)
    else $error("privileged op executed");
  chk_sk_sign: assert property (@(posedge mclk) disable iff (!rst_n)
    fk == 3'h0 |-> operand_sk == 64'h8000_0000_0000_0000 && operand_ak == 32'h1)
    else $error("bad zero substitute");
  chk_narrow_imm: assert property (@(posedge mclk) disable iff (!rst_n)
    issue_valid && !wide_addressing_bit |-> immediate[31:24] == 8'h00)
    else $error("narrow upper bits kept");
  chk_wide_reject: assert property (@(posedge mclk) disable iff (!rst_n)
    issue_valid && gh == 7'h01 && wide_addressing_bit |-> mode_error)
    else $error("01 accepted in wide mode");
  chk_cmp_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(cmp_busy) |-> ##[1:66] !cmp_busy)
    else $error("compress walk overran");
  chk_queue_cap: assert property (@(posedge mclk) disable iff (!rst_n) cnt_q <= 3'd6)
    else $error("parcel queue overflow");
endmodule

// *** tb/fetch_model.sv ***
/*
 * fetch-side model: a word memory streamed to the decoder over the
 * word_valid/word_ready handshake, with stalls on request.
 * assumes the bench fills mem and nwords before raising go.
 */
`timescale 1ns/100ps

module fetch_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic        hold_off,
  input  wire logic [6:0]  nwords,
  input  wire logic        branch_take,
  input  wire logic [23:0] branch_parcel,
  input  wire logic        word_ready,
  output logic             word_valid = 1'b0,
  output logic [63:0]      word_data = 64'h0
);
  logic [63:0] mem [0:63];
  logic [6:0]  ptr_q = 7'h00;
  logic [6:0]  next_ptr;

  assign next_ptr = word_valid ? ptr_q + 7'h01 : ptr_q;

  // ----------------------------------------------------------------
  // word stream
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      ptr_q      <= 7'h00;
      word_valid <= 1'b0;
    end else if (branch_take) begin
      ptr_q      <= {1'b0, branch_parcel[7:2]};
      word_valid <= 1'b0;
      word_data  <= ~word_data;
    end else if (!(word_valid && !word_ready)) begin
      ptr_q <= next_ptr;
      if (go && !hold_off && next_ptr < nwords) begin
        word_valid <= 1'b1;
        word_data  <= mem[next_ptr[5:0]];
      end else begin
        // released bus shows no stale word
        word_valid <= 1'b0;
        word_data  <= ~word_data;
      end
    end
  end
endmodule

// *** tb/parcel_instruction_decoder_test.sv ***
/*
 * bench for the parcel decoder: builds parcel programs, streams them
 * through the fetch model and checks every issued instruction in order.
 * assumes the decoder, its package and the fetch model compile first.
 */
`timescale 1ns/100ps
`include "parcel_decoder_map.svh"

module parcel_instruction_decoder_test;
  import parcel_decoder_pkg::*;

  typedef struct {
    length_t     len;
    format_t     fmt;
    logic        chk_fmt;
    logic [15:0] p0, p1, p2;
  } instr_t;

  logic        mclk = 1'b0, rst_n = 1'b0, go = 1'b0, hold_off = 1'b0, branch_take = 1'b0;
  logic [6:0]  nwords = 7'h00, vector_length = 7'h01;
  logic [23:0] branch_parcel = 24'h000000;
  logic        wide_addressing_bit = 1'b0, monitor_mode = 1'b0;
  logic [63:0] pat = 64'h0;
  logic        elem_nonzero;
  logic        word_valid, word_ready, issue_valid, use_real_zero_i, skip_reserve_j, skip_reserve_k;
  logic        issue_nop, mode_error, cmp_pack, cmp_busy;
  logic [63:0] word_data, operand_sj, operand_sk, vector_mask;
  length_t     issue_length;
  format_t     issue_format;
  logic [6:0]  opcode_gh, cmp_index;
  logic [2:0]  field_h, field_i, field_j, field_k;
  logic [5:0]  field_jk;
  logic [31:0] immediate, operand_ah, operand_aj, operand_ak;
  logic [23:0] branch_target;
  instr_t      exp_q[$];
  logic [15:0] pq[$];
  integer      seed = 32'h5F0F;
  int          error_cnt = 0, cmp_count = 0, pack_n = 0;

  assign elem_nonzero = pat[cmp_index[5:0]];

  initial forever #25 mclk = ~mclk;

  fetch_model u_fetch (.mclk(mclk), .rst_n(rst_n), .go(go), .hold_off(hold_off), .nwords(nwords),
    .branch_take(branch_take), .branch_parcel(branch_parcel), .word_ready(word_ready),
    .word_valid(word_valid), .word_data(word_data));

  parcel_instruction_decoder dut (.mclk(mclk), .rst_n(rst_n), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready), .branch_take(branch_take),
    .branch_parcel(branch_parcel), .wide_addressing_bit(wide_addressing_bit),
    .monitor_mode(monitor_mode), .address_reg_zero(32'h0000_0000), .scalar_reg_zero(64'h0),
    .vector_length(vector_length), .elem_nonzero(elem_nonzero), .issue_valid(issue_valid),
    .issue_length(issue_length), .issue_format(issue_format), .opcode_gh(opcode_gh),
    .field_h(field_h), .field_i(field_i), .field_j(field_j), .field_k(field_k),
    .field_jk(field_jk), .immediate(immediate), .branch_target(branch_target),
    .operand_ah(operand_ah), .operand_aj(operand_aj), .operand_ak(operand_ak),
    .operand_sj(operand_sj), .operand_sk(operand_sk), .use_real_zero_i(use_real_zero_i),
    .skip_reserve_j(skip_reserve_j), .skip_reserve_k(skip_reserve_k), .issue_nop(issue_nop),
    .mode_error(mode_error), .vector_mask(vector_mask), .cmp_index(cmp_index),
    .cmp_pack(cmp_pack), .cmp_busy(cmp_busy));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    cmp_count++;
    if (got !== want) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  function automatic logic [63:0] mask_exp(input logic [63:0] p, input int vl);
    logic [63:0] m;
    m = 64'h0;
    for (int x = 0; x < vl; x++) m[63 - x] = p[x];
    return m;
  endfunction

  task automatic check_issue(input instr_t e);
    logic bad01;
    bad01 = (e.p0[15:9] == `PD_GH_AH_IMM) && wide_addressing_bit;
    chk(issue_length, e.len);
    if (e.chk_fmt) chk(issue_format, e.fmt);
    chk(opcode_gh, e.p0[15:9]);
    chk({field_h, field_i, field_j, field_k}, e.p0[11:0]);
    chk(field_jk, e.p0[5:0]);
    chk(mode_error, (e.len == FMT_TWO && e.p0[15:14] == 2'b10 && e.p0[5:0] == 6'h00) || bad01);
    if (e.len == FMT_ONE) begin
      chk(issue_nop, (e.p0[15:9] == `PD_GH_CHAN && e.p0[8:6] != 3'h0 && !monitor_mode) || bad01);
      if (e.p0[5:3] == 3'h0) chk(operand_aj, 32'h0);
      if (e.p0[5:3] == 3'h0) chk(operand_sj, 64'h0);
      if (e.p0[2:0] == 3'h0) chk(operand_ak, `PD_A_ONE);
      if (e.p0[2:0] == 3'h0) chk(operand_sk, `PD_S_SIGN);
    end else begin
      if (e.p0[11:9] == 3'h0) chk(operand_ah, 32'h0);
      if (e.fmt == KIND_BRANCH) chk(branch_target, {e.p0[7:0], e.p1});
      else if (e.fmt == KIND_IMM24) chk(immediate, {8'h00, e.p0[7:0], e.p1});
      else chk(immediate, e.len == FMT_THREE ? {e.p2, e.p1} : {10'h000, e.p0[5:0], e.p1});
    end
  endtask

  always @(negedge mclk) begin
    if (rst_n && issue_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1, 0);
      else check_issue(exp_q.pop_front());
    end
    if (rst_n && cmp_pack === 1'b1) pack_n++;
  end

  // ----------------------------------------------------------------
  // program building and phases
  // ----------------------------------------------------------------
  task automatic add(input length_t len, input format_t fmt, input logic cf, input logic [15:0] a, b, c);
    instr_t e;
    e = '{len, fmt, cf, a, b, c};
    exp_q.push_back(e);
    pq.push_back(a);
    if (len != FMT_ONE) pq.push_back(b);
    if (len == FMT_THREE) pq.push_back(c);
  endtask

  task automatic ones(input int n);
    logic [15:0] r;
    repeat (n) begin
      r = $random(seed);
      r[15:14] = 2'b11;
      if (r[0]) r[5:0] = 6'h00;
      add(FMT_ONE, KIND_DISCRETE, 1'b0, r, 16'h0, 16'h0);
    end
  endtask

  task automatic mem(input logic three);
    logic [15:0] a, b, c;
    a = $random(seed);
    b = $random(seed);
    c = $random(seed);
    a[15:14] = 2'b10;
    if (three) a[5:0] = 6'h00;
    if (three) add(FMT_THREE, KIND_MEM32, 1'b1, a, b, c);
    else add(FMT_TWO, KIND_MEM22, 1'b1, a, b, c);
  endtask

  task automatic load();
    int w;
    while (pq.size() % 4 != 0) ones(1);
    nwords <= 7'(pq.size() / 4);
    for (w = 0; w < pq.size() / 4; w++) u_fetch.mem[w] = {pq[4*w], pq[4*w+1], pq[4*w+2], pq[4*w+3]};
    pq.delete();
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic run_phase();
    int n;
    @(posedge mclk);
    go <= 1'b1;
    for (n = 0; n < 3000 && exp_q.size() != 0; n++) begin
      @(posedge mclk);
      hold_off <= $random(seed);
    end
    chk(exp_q.size(), 0);
    repeat (8) @(posedge mclk);
    go <= 1'b0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end

  initial begin
    do_reset();
    // narrow: two-parcel from parcel 3 crosses the word edge
    ones(3);
    mem(1'b0);
    add(FMT_TWO, KIND_MEM22, 1'b1, 16'h8A00, 16'h1234, 16'h0000);
    add(FMT_ONE, KIND_DISCRETE, 1'b0, 16'h0040, 16'h0000, 16'h0000);
    repeat (24) if ($random(seed) & 1) ones(1); else mem(1'b0);
    load();
    run_phase();
    // wide: three-parcel forms, one starting at parcel 3
    wide_addressing_bit <= 1'b1;
    monitor_mode <= 1'b1;
    do_reset();
    ones(2);
    mem(1'b1);
    ones(2);
    mem(1'b1);
    add(FMT_TWO, KIND_IMM24, 1'b1, 16'h0BC5, 16'hA55A, 16'h0000);
    add(FMT_TWO, KIND_BRANCH, 1'b1, 16'h0C9C, 16'h1357, 16'h0000);
    add(FMT_ONE, KIND_DISCRETE, 1'b0, 16'h0240, 16'h0000, 16'h0000);
    repeat (16) if ($random(seed) & 1) ones(1); else mem(1'b1);
    load();
    run_phase();
    // branch into parcel 2 of word 1
    do_reset();
    ones(12);
    load();
    repeat (6) void'(exp_q.pop_front());
    branch_parcel <= 24'h000006;
    branch_take <= 1'b1;
    @(posedge mclk);
    branch_take <= 1'b0;
    run_phase();
    // compressed index walk, random and full length
    for (int v = 0; v < 2; v++) begin
      do_reset();
      pat <= {$random(seed), $random(seed)};
      vector_length <= v ? 7'h40 : 7'(($random(seed) & 63) + 1);
      pack_n = 0;
      add(FMT_ONE, KIND_DISCRETE, 1'b0, {`PD_GH_CMPIDX, 9'h1FF}, 16'h0, 16'h0);
      ones(3);
      load();
      run_phase();
      repeat (200) if (cmp_busy === 1'b1) @(posedge mclk);
      chk(cmp_busy, 1'b0);
      chk(vector_mask, mask_exp(pat, int'(vector_length)));
      chk(pack_n, $countones(mask_exp(pat, int'(vector_length))));
    end
    complete_run();
  end
endmodule
